/* File: temp_top.sv */
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`include "temp_cfg.svh"
// Operation
// RULE1: Each engine: 32 inputs, 32 outputs, time-base clock
// RULE2: Stop bit halts only its own engine
// RULE3: Disable waits for running thread to finish
// RULE4: Disabled engine stops sampling; bus stays accessible
// RULE5: System stop request halts engines
// RULE6: Code memory access only in configuration mode
// RULE7: Output set by force or event action
// RULE8: One buffer enable per channel from microcode
// RULE9: Input filter drops pulses narrower than width
// RULE10: Four group disable inputs, eight channels each
// RULE11: Selected disabled channels drive inverse polarity
// RULE12: Disable inputs map to groups in order
// RULE13: Time-base input gates clock-by-eight accumulator
// RULE14: Angle mode takes tooth edges from input
// RULE15: Decode system and time-base register ranges
// RULE16: Decode channel ranges, rest reserved
// RULE17: Parameter RAM plus sign-extending mirror
// RULE18: Code memory, then fill-value gap region
// RULE19: Host writes code memory only when visible
// RULE20: Mirror returns sign-extended parameter data
module temp_top
#(
    parameter int NCH        = 32,
    parameter int PRAM_WORDS = 768,
    parameter int SCM_WORDS  = 3072
)
(
    input  wire logic                 MCLK_IN,
    input  wire logic                 RSTN_IN,
    input  wire logic                 PSEL_IN,
    input  wire logic                 PENABLE_IN,
    input  wire logic                 PWRITE_IN,
    input  wire logic [16:0]          PADDR_IN,
    input  wire logic [31:0]          PWDATA_IN,
    output logic      [31:0]          PRDATA_OUT,
    output logic                      PREADY_OUT,
    output logic                      PSLVERR_OUT,
    input  wire logic [2*NCH-1:0]     CH_IN,
    input  wire logic [2*NCH-1:0]     CH_FORCE_EN_IN,
    input  wire logic [2*NCH-1:0]     CH_FORCE_VAL_IN,
    input  wire logic [2*NCH-1:0]     CH_EVT_IN,
    input  wire logic [2*NCH-1:0]     CH_ACT_VAL_IN,
    input  wire logic [2*NCH-1:0]     CH_OBE_IN,
    input  wire logic [1:0]           THREAD_BUSY_IN,
    input  wire logic [7:0]           OUT_DIS_IN,
    input  wire logic [1:0]           TB_CLK_IN,
    input  wire logic                 SYS_STOP_IN,
    output logic      [2*NCH-1:0]     CH_OUT,
    output logic      [2*NCH-1:0]     CH_OBE_OUT,
    output logic      [2*NCH-1:0]     CH_FILT_OUT,
    output logic      [1:0]           ENG_CLK_EN_OUT,
    output logic      [1:0]           TOOTH_OUT,
    output logic                      STOP_ACK_OUT
);
    import temp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [PRAM_WORDS-1:0][31:0] pram;
        logic [SCM_WORDS-1:0][31:0]  shared_code_memory;
        logic [31:0]                 fill;
        logic                        code_memory_visibility_bit;
        logic [1:0]                  stop_bit;
        logic [1:0][3:0]             fw;
        logic [1:0][1:0]             tbm;
        temp_eng_t [1:0]             eng;
        logic [2*NCH-1:0]            pol;
        logic [2*NCH-1:0]            sel;
        logic [2*NCH-1:0]            ch_s1;
        logic [2*NCH-1:0]            ch_s2;
        logic [2*NCH-1:0]            filt;
        logic [2*NCH-1:0][3:0]       fcnt;
        logic [2*NCH-1:0]            lvl;
        logic [2*NCH-1:0]            obe;
        logic [2*NCH-1:0]            ch_out;
        logic [7:0]                  od_s1;
        logic [7:0]                  od_s2;
        logic [1:0]                  tb_s1;
        logic [1:0]                  tb_s2;
        logic [1:0]                  tb_prev;
        logic [1:0][2:0]             presc;
        logic [1:0][31:0]            pacc;
        logic [1:0]                  tooth;
        logic                        stop_s1;
        logic                        stop_s2;
        logic                        stop_ack;
        logic [1:0]                  clk_en;
        logic [31:0]                 prdata;
        logic                        pready;
        logic                        pslverr;
    } temp_state_t;

    temp_state_t s_q;
    temp_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic temp_region_t temp_decode(input logic [16:0] a);
        temp_region_t r;
        r = TEMP_R_NONE;
        if (a <= `TEMP_SYS_LAST)
            r = TEMP_R_SYS; // [RULE15]
        else if (a >= `TEMP_TBA_FIRST && a <= `TEMP_TBA_LAST)
            r = TEMP_R_TBA; // [RULE15]
        else if (a >= `TEMP_TBB_FIRST && a <= `TEMP_TBB_LAST)
            r = TEMP_R_TBB; // [RULE15]
        else if (a >= `TEMP_GLB_FIRST && a <= `TEMP_GLB_LAST)
            r = TEMP_R_GLB; // [RULE16]
        else if (a >= `TEMP_CHA_FIRST && a <= `TEMP_CHA_LAST)
            r = TEMP_R_CHA; // [RULE16]
        else if (a >= `TEMP_CHB_FIRST && a <= `TEMP_CHB_LAST)
            r = TEMP_R_CHB; // [RULE16]
        else if (a >= `TEMP_PRAM_FIRST && a <= `TEMP_PRAM_LAST)
            r = TEMP_R_PRAM; // [RULE17]
        else if (a >= `TEMP_PSE_FIRST && a <= `TEMP_PSE_LAST)
            r = TEMP_R_PSE; // [RULE17]
        else if (a >= `TEMP_SCM_FIRST && a <= `TEMP_SCM_LAST)
            r = TEMP_R_SCM; // [RULE18]
        else if (a >= `TEMP_GAP_FIRST)
            r = TEMP_R_GAP; // [RULE18]
        return r;
    endfunction : temp_decode

    ////////////////////////////////////////////////////////////////////////
    // Channel configuration word: engine A or B block, first word of slot
    function automatic logic temp_ccfg_hit(input logic [16:0] a);
        logic blk;
        logic slot;
        blk  = (a[11:9] == 3'b010) || (a[11:9] == 3'b100);
        slot = (a[3:2] == 2'b00);
        return blk && slot;
    endfunction : temp_ccfg_hit

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        temp_region_t rg;
        logic [16:0]  a;
        logic [9:0]   pidx;
        logic [11:0]  sidx;
        logic [5:0]   cidx;
        logic [31:0]  rd;
        logic         err;
        logic         run;
        logic         od;
        int           i;
        rg   = temp_decode(PADDR_IN);
        a    = PADDR_IN;
        pidx = 10'(a[11:2]);
        sidx = 12'(a[13:2] - 12'h000);
        cidx = {a[11], a[8:4]};
        rd   = 32'h00000000;
        err  = 1'b0;
        run  = 1'b0;
        od   = 1'b0;
        i    = 0;
        s_d  = s_q;

        // Synchronisers for pins
        s_d.ch_s1   = CH_IN; // [RULE1]
        s_d.od_s1   = OUT_DIS_IN; // [RULE10]
        s_d.od_s2   = s_q.od_s1;
        s_d.tb_s1   = TB_CLK_IN; // [RULE1]
        s_d.tb_s2   = s_q.tb_s1;
        s_d.tb_prev = s_q.tb_s2;
        s_d.stop_s1 = SYS_STOP_IN;
        s_d.stop_s2 = s_q.stop_s1;

        // Setup phase: read data and error registered for access phase
        s_d.pready = PSEL_IN && !PENABLE_IN;
        if (PSEL_IN && !PENABLE_IN)
        begin
            unique case (rg)
                TEMP_R_SYS:
                begin
                    if (a[4:0] == `TEMP_MCFG_OFS)
                        rd[`TEMP_MCFG_VIS_BIT] = s_q.code_memory_visibility_bit;
                    else if (a[4:0] == `TEMP_FILL_OFS)
                        rd = s_q.fill;
                    else if (a[4:0] == `TEMP_ECFG_A_OFS ||
                             a[4:0] == `TEMP_ECFG_B_OFS)
                    begin
                        i = (a[4:0] == `TEMP_ECFG_B_OFS) ? 1 : 0;
                        rd[`TEMP_ECFG_STOP_BIT] = s_q.stop_bit[i];
                        rd[`TEMP_ECFG_FW_LSB +: 4] = s_q.fw[i];
                        rd[`TEMP_ECFG_TBM_LSB +: 2] = s_q.tbm[i];
                        rd[`TEMP_ECFG_OFF_BIT] =
                            (s_q.eng[i] == TEMP_ENG_OFF);
                    end
                end
                TEMP_R_TBA, TEMP_R_TBB:
                begin
                    i = (rg == TEMP_R_TBB) ? 1 : 0;
                    if (a[3:0] == `TEMP_PACC_OFS)
                        rd = s_q.pacc[i];
                end
                TEMP_R_CHA, TEMP_R_CHB:
                begin
                    if (temp_ccfg_hit(a))
                    begin
                        rd[`TEMP_CCFG_POL_BIT] = s_q.pol[cidx];
                        rd[`TEMP_CCFG_SEL_BIT] = s_q.sel[cidx];
                    end
                end
                TEMP_R_PRAM:
                    if (pidx < 10'(PRAM_WORDS))
                        rd = s_q.pram[pidx];
                TEMP_R_PSE:
                    if (pidx < 10'(PRAM_WORDS))
                        rd = {{8{s_q.pram[pidx][`TEMP_SIGN_BIT]}},
                              s_q.pram[pidx][23:0]}; // [RULE17] [RULE20]
                TEMP_R_SCM:
                begin
                    if (!s_q.code_memory_visibility_bit)
                        err = 1'b1; // [RULE6] [RULE19]
                    else if (sidx < 12'(SCM_WORDS))
                        rd = s_q.shared_code_memory[sidx];
                end
                TEMP_R_GAP:
                    rd = s_q.fill; // [RULE18]
                TEMP_R_GLB:
                    rd = 32'h00000000; // [RULE4]
                TEMP_R_NONE:
                    err = 1'b1; // [RULE16]
            endcase
            s_d.prdata  = PWRITE_IN ? 32'h00000000 : rd;
            s_d.pslverr = err;
        end

        // Access phase: write takes effect on the ready edge
        if (PSEL_IN && PENABLE_IN && s_q.pready && PWRITE_IN &&
            !s_q.pslverr)
        begin
            unique case (rg)
                TEMP_R_SYS:
                begin
                    if (a[4:0] == `TEMP_MCFG_OFS)
                        s_d.code_memory_visibility_bit = PWDATA_IN[`TEMP_MCFG_VIS_BIT];
                    else if (a[4:0] == `TEMP_FILL_OFS)
                        s_d.fill = PWDATA_IN;
                    else if (a[4:0] == `TEMP_ECFG_A_OFS ||
                             a[4:0] == `TEMP_ECFG_B_OFS)
                    begin
                        i = (a[4:0] == `TEMP_ECFG_B_OFS) ? 1 : 0;
                        s_d.stop_bit[i] =
                            PWDATA_IN[`TEMP_ECFG_STOP_BIT]; // [RULE2]
                        s_d.fw[i]  = PWDATA_IN[`TEMP_ECFG_FW_LSB +: 4];
                        s_d.tbm[i] = PWDATA_IN[`TEMP_ECFG_TBM_LSB +: 2];
                    end
                end
                TEMP_R_CHA, TEMP_R_CHB:
                begin
                    if (temp_ccfg_hit(a))
                    begin
                        s_d.pol[cidx] = PWDATA_IN[`TEMP_CCFG_POL_BIT];
                        s_d.sel[cidx] = PWDATA_IN[`TEMP_CCFG_SEL_BIT];
                    end
                end
                TEMP_R_PRAM, TEMP_R_PSE:
                    if (pidx < 10'(PRAM_WORDS))
                        s_d.pram[pidx] = PWDATA_IN;
                TEMP_R_SCM:
                    if (sidx < 12'(SCM_WORDS))
                        s_d.shared_code_memory[sidx] = PWDATA_IN; // [RULE6]
                TEMP_R_TBA, TEMP_R_TBB, TEMP_R_GLB, TEMP_R_GAP,
                TEMP_R_NONE:
                    s_d.fill = s_q.fill; // [RULE18]
            endcase
        end

        // Engines
        for (int e = 0; e < 2; e++)
        begin
            unique case (s_q.eng[e])
                TEMP_ENG_RUN:
                    if (s_q.stop_bit[e])
                        s_d.eng[e] = THREAD_BUSY_IN[e] ?
                            TEMP_ENG_DRAIN : TEMP_ENG_OFF; // [RULE3]
                TEMP_ENG_DRAIN:
                    if (!s_q.stop_bit[e])
                        s_d.eng[e] = TEMP_ENG_RUN;
                    else if (!THREAD_BUSY_IN[e])
                        s_d.eng[e] = TEMP_ENG_OFF; // [RULE3]
                TEMP_ENG_OFF:
                    if (!s_q.stop_bit[e])
                        s_d.eng[e] = TEMP_ENG_RUN;
                default:
                    s_d.eng[e] = TEMP_ENG_RUN;
            endcase
            run = (s_q.eng[e] != TEMP_ENG_OFF) && !s_q.stop_s2; // [RULE5]
            s_d.clk_en[e] = (s_d.eng[e] != TEMP_ENG_OFF) &&
                            !s_q.stop_s2; // [RULE2] [RULE5]

            // Time-base input
            s_d.tooth[e] = 1'b0;
            if (run)
            begin
                s_d.presc[e] = s_q.presc[e] + 3'h1;
                if (s_q.tbm[e] == TEMP_TB_PACC &&
                    s_q.presc[e] == 3'(`TEMP_PACC_DIV - 1) &&
                    s_q.tb_s2[e])
                    s_d.pacc[e] = s_q.pacc[e] + 32'h00000001; // [RULE13]
                if (s_q.tbm[e] == TEMP_TB_ANGLE)
                    s_d.tooth[e] = s_q.tb_s2[e] &&
                                   !s_q.tb_prev[e]; // [RULE14]
            end

            // Channels
            for (int c = 0; c < NCH; c++)
            begin
                i = e * NCH + c;
                if (run)
                begin
                    s_d.ch_s2[i] = s_q.ch_s1[i]; // [RULE4]
                    if (s_q.ch_s2[i] != s_q.filt[i])
                    begin
                        if (s_q.fcnt[i] >= s_q.fw[e])
                        begin
                            s_d.filt[i] = s_q.ch_s2[i]; // [RULE9]
                            s_d.fcnt[i] = 4'h0;
                        end
                        else
                            s_d.fcnt[i] = s_q.fcnt[i] + 4'h1;
                    end
                    else
                        s_d.fcnt[i] = 4'h0; // [RULE9]
                    if (CH_FORCE_EN_IN[i])
                        s_d.lvl[i] = CH_FORCE_VAL_IN[i]; // [RULE7]
                    else if (CH_EVT_IN[i])
                        s_d.lvl[i] = CH_ACT_VAL_IN[i]; // [RULE7]
                    s_d.obe[i] = CH_OBE_IN[i]; // [RULE8]
                end
                od = s_q.od_s2[e * 4 + c / 8]; // [RULE10] [RULE12]
                s_d.ch_out[i] = (od && s_q.sel[i]) ?
                    !s_q.pol[i] : s_d.lvl[i]; // [RULE11]
            end
        end
        s_d.stop_ack = s_q.stop_s2 && (THREAD_BUSY_IN == 2'b00); // [RULE5]
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge MCLK_IN or negedge RSTN_IN)
    begin
        if (!RSTN_IN)
        begin
            s_q       <= '0;
            s_q.fill  <= `TEMP_FILL_RST;
            s_q.fw    <= {2{`TEMP_FW_RST}};
        end
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign PRDATA_OUT     = s_q.prdata;
    assign PREADY_OUT     = s_q.pready;
    assign PSLVERR_OUT    = s_q.pslverr;
    assign CH_OUT         = s_q.ch_out;
    assign CH_OBE_OUT     = s_q.obe;
    assign CH_FILT_OUT    = s_q.filt;
    assign ENG_CLK_EN_OUT = s_q.clk_en;
    assign TOOTH_OUT      = s_q.tooth;
    assign STOP_ACK_OUT   = s_q.stop_ack;

endmodule : temp_top

/* File: temp_cfg.svh */
`ifndef TEMP_CFG_SVH
`define TEMP_CFG_SVH

// Region bounds, byte offsets from block base
`define TEMP_SYS_LAST      17'h0001F
`define TEMP_TBA_FIRST     17'h00020
`define TEMP_TBA_LAST      17'h0002F
`define TEMP_TBB_FIRST     17'h00040
`define TEMP_TBB_LAST      17'h0004F
`define TEMP_GLB_FIRST     17'h00200
`define TEMP_GLB_LAST      17'h002FF
`define TEMP_CHA_FIRST     17'h00400
`define TEMP_CHA_LAST      17'h007FF
`define TEMP_CHB_FIRST     17'h00800
`define TEMP_CHB_LAST      17'h00BFF
`define TEMP_PRAM_FIRST    17'h08000
`define TEMP_PRAM_LAST     17'h08BFF
`define TEMP_PSE_FIRST     17'h0C000
`define TEMP_PSE_LAST      17'h0CBFF
`define TEMP_SCM_FIRST     17'h10000
`define TEMP_SCM_LAST      17'h12FFF
`define TEMP_GAP_FIRST     17'h13000
`define TEMP_GAP_LAST      17'h1FFFF

// Registers in the system region
`define TEMP_MCFG_OFS      5'h00
`define TEMP_FILL_OFS      5'h14
`define TEMP_ECFG_A_OFS    5'h10
`define TEMP_ECFG_B_OFS    5'h18
// Pulse accumulator count, offset within a time-base block
`define TEMP_PACC_OFS      4'h4

// Field positions
`define TEMP_MCFG_VIS_BIT  0
`define TEMP_ECFG_STOP_BIT 0
`define TEMP_ECFG_FW_LSB   4
`define TEMP_ECFG_TBM_LSB  8
`define TEMP_ECFG_OFF_BIT  31
`define TEMP_CCFG_POL_BIT  0
`define TEMP_CCFG_SEL_BIT  1
`define TEMP_SIGN_BIT      23

// Reset values
`define TEMP_FILL_RST      32'h00000000
`define TEMP_FW_RST        4'h0

// Timing
`define TEMP_PACC_DIV      8

`endif

/* File: temp_pkg.sv */
package temp_pkg;

    typedef enum logic [1:0]
    {
        TEMP_ENG_RUN   = 2'b00,
        TEMP_ENG_DRAIN = 2'b01,
        TEMP_ENG_OFF   = 2'b10
    } temp_eng_t;

    typedef enum logic [1:0]
    {
        TEMP_TB_NONE  = 2'b00,
        TEMP_TB_PACC  = 2'b01,
        TEMP_TB_ANGLE = 2'b10
    } temp_tbm_t;

    typedef enum logic [3:0]
    {
        TEMP_R_NONE = 4'h0,
        TEMP_R_SYS  = 4'h1,
        TEMP_R_TBA  = 4'h2,
        TEMP_R_TBB  = 4'h3,
        TEMP_R_GLB  = 4'h4,
        TEMP_R_CHA  = 4'h5,
        TEMP_R_CHB  = 4'h6,
        TEMP_R_PRAM = 4'h7,
        TEMP_R_PSE  = 4'h8,
        TEMP_R_SCM  = 4'h9,
        TEMP_R_GAP  = 4'hA
    } temp_region_t;

endpackage : temp_pkg

/* File: temp_pad_model.sv */
`timescale 1ns/1ns
module temp_pad_model
#(
    parameter int NCH = 32
)
(
    input  wire logic [2*NCH-1:0] pad_drv_in,
    input  wire logic [2*NCH-1:0] out_in,
    input  wire logic [2*NCH-1:0] obe_in,
    output logic      [2*NCH-1:0] pad_out
);
    // Enabled buffer owns the shared pin
    assign pad_out = (obe_in & out_in) | (~obe_in & pad_drv_in);
endmodule : temp_pad_model

/* File: temp_bus_checker.sv */
`timescale 1ns/1ns
module temp_bus_checker
#(
    parameter int NCH = 32
)
(
    input wire logic             MCLK_IN,
    input wire logic             RSTN_IN,
    input wire logic             PSEL_IN,
    input wire logic             PENABLE_IN,
    input wire logic             PWRITE_IN,
    input wire logic [16:0]      PADDR_IN,
    input wire logic [31:0]      PRDATA_OUT,
    input wire logic             PREADY_OUT,
    input wire logic             PSLVERR_OUT,
    input wire logic [2*NCH-1:0] CH_FORCE_EN_IN,
    input wire logic [2*NCH-1:0] CH_FORCE_VAL_IN,
    input wire logic [7:0]       OUT_DIS_IN,
    input wire logic [1:0]       THREAD_BUSY_IN,
    input wire logic             SYS_STOP_IN,
    input wire logic [2*NCH-1:0] CH_OUT,
    input wire logic [1:0]       ENG_CLK_EN_OUT,
    input wire logic [1:0]       TOOTH_OUT,
    input wire logic             STOP_ACK_OUT
);
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RSTN_IN);
    ////////////////////////////////////////
    ready_after_setup_a:
        assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
        else $error("ready missing after setup");
    ready_cause_a:
        assert property (PREADY_OUT |-> $past(PSEL_IN) && !$past(PENABLE_IN))
        else $error("ready without setup");
    sys_hole_err_a:
        assert property (PSEL_IN && !PENABLE_IN && !PWRITE_IN
            && PADDR_IN inside {[17'h00030:17'h0003F]}
            |=> PSLVERR_OUT && PRDATA_OUT == 32'h00000000)
        else $error("reserved system hole not refused");
    chan_hole_err_a:
        assert property (PSEL_IN && !PENABLE_IN && PADDR_IN inside
            {[17'h00300:17'h003FF], [17'h00C00:17'h07FFF]} |=> PSLVERR_OUT)
        else $error("reserved channel hole not refused");
    fill_no_err_a:
        assert property (PSEL_IN && !PENABLE_IN && PADDR_IN >= 17'h13000
            |=> PREADY_OUT && !PSLVERR_OUT)
        else $error("fill region gave error");
    drain_wait_a:
        assert property ($fell(ENG_CLK_EN_OUT[0]) && !STOP_ACK_OUT
            && !$past(SYS_STOP_IN, 3) |-> !$past(THREAD_BUSY_IN[0]))
        else $error("engine stopped during thread");
    tooth_pulse_a:
        assert property (TOOTH_OUT[0] |=> !TOOTH_OUT[0])
        else $error("tooth pulse too long");
    force_level_a:
        assert property (CH_FORCE_EN_IN[0] && !$past(OUT_DIS_IN[0], 2)
            |=> CH_OUT[0] == $past(CH_FORCE_VAL_IN[0]))
        else $error("forced level not driven");
    stop_halts_a:
        assert property ($rose(STOP_ACK_OUT) |-> ##[0:2]
            (ENG_CLK_EN_OUT == 2'b00))
        else $error("engines run in system stop");
endmodule : temp_bus_checker

/* File: tb_top.sv */
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
    begin \
        tests_run++; \
        if ((got) !== (ex)) \
        begin \
            num_errors++; \
            $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
        end \
    end
module tb_top;
    localparam int NCH = 32;
    logic             MCLK_IN, RSTN_IN, PSEL_IN, PENABLE_IN, PWRITE_IN;
    logic             PREADY_OUT, PSLVERR_OUT, SYS_STOP_IN, STOP_ACK_OUT;
    logic [16:0]      PADDR_IN;
    logic [31:0]      PWDATA_IN, PRDATA_OUT, rd, c1;
    logic [2*NCH-1:0] CH_IN, CH_FORCE_EN_IN, CH_FORCE_VAL_IN, CH_EVT_IN;
    logic [2*NCH-1:0] CH_ACT_VAL_IN, CH_OBE_IN, CH_OUT, CH_OBE_OUT;
    logic [2*NCH-1:0] CH_FILT_OUT, pad_drv;
    logic [1:0]       THREAD_BUSY_IN, TB_CLK_IN, ENG_CLK_EN_OUT, TOOTH_OUT;
    logic [7:0]       OUT_DIS_IN;
    logic             err;
    int               num_errors, tests_run, cycles, teeth;
    logic [16:0]      dec_a [12] = '{17'h00020, 17'h0004C, 17'h00030,
        17'h001FC, 17'h002FC, 17'h00300, 17'h005F0, 17'h00BFC,
        17'h00C00, 17'h08C00, 17'h0CC00, 17'h10000};
    logic             dec_e [12] = '{0, 0, 1, 1, 0, 1, 0, 0, 1, 1, 1, 1};

    temp_top #(.NCH(NCH)) i_dut (.*);
    temp_pad_model #(.NCH(NCH)) i_pad (.pad_drv_in(pad_drv),
        .out_in(CH_OUT), .obe_in(CH_OBE_OUT), .pad_out(CH_IN));
    ////////////////////////////////////////
    initial
    begin
        MCLK_IN = 1'b0;
        forever #50 MCLK_IN = ~MCLK_IN;
    end

    always @(negedge MCLK_IN)
    begin
        cycles++;
        if (TOOTH_OUT[0] === 1'b1)
            teeth++;
        if (cycles == 20000)
        begin
            num_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic apb(input logic w, input logic [16:0] a,
                       input logic [31:0] d, input logic ee);
        int n;
        @(posedge MCLK_IN);
        PSEL_IN <= 1'b1;
        PWRITE_IN <= w;
        PADDR_IN <= a;
        PWDATA_IN <= d;
        @(posedge MCLK_IN);
        PENABLE_IN <= 1'b1;
        n = 0;
        do
        begin
            @(posedge MCLK_IN);
            n++;
        end while (PREADY_OUT !== 1'b1);
        rd = PRDATA_OUT;
        err = PSLVERR_OUT;
        PSEL_IN <= 1'b0;
        PENABLE_IN <= 1'b0;
        `CHK("ready wait", 1, n)
        `CHK("bus error", ee, err)
    endtask : apb
    ////////////////////////////////////////
    initial
    begin
        RSTN_IN = 1'b0;
        {PSEL_IN, PENABLE_IN, PWRITE_IN, SYS_STOP_IN} = '0;
        {PADDR_IN, PWDATA_IN, pad_drv, CH_OBE_IN} = '0;
        {CH_FORCE_EN_IN, CH_FORCE_VAL_IN, CH_EVT_IN, CH_ACT_VAL_IN} = '0;
        {THREAD_BUSY_IN, TB_CLK_IN, OUT_DIS_IN} = '0;
        repeat (8) @(posedge MCLK_IN);
        RSTN_IN <= 1'b1;
        repeat (2) @(posedge MCLK_IN);
        `CHK("clock enables", 2'b11, ENG_CLK_EN_OUT)
        apb(0, 17'h14, 0, 0);
        `CHK("fill reset", 32'h00000000, rd)
        foreach (dec_a[i])
            apb(0, dec_a[i], 0, dec_e[i]);
        apb(1, 17'h14, 32'hA5A50F0F, 0);
        apb(1, 17'h13000, 32'h12345678, 0);
        apb(0, 17'h13000, 0, 0);
        `CHK("fill read", 32'hA5A50F0F, rd)
        apb(1, 17'h00, 32'h1, 0);
        apb(1, 17'h12FFC, 32'hCAFE0001, 0);
        apb(0, 17'h12FFC, 0, 0);
        `CHK("code word", 32'hCAFE0001, rd)
        apb(1, 17'h00, 32'h0, 0);
        apb(0, 17'h10000, 0, 1);
        $display("test decode done");
        apb(1, 17'h08010, 32'h00800001, 0);
        apb(0, 17'h0C010, 0, 0);
        `CHK("mirror", 32'hFF800001, rd)
        apb(0, 17'h08010, 0, 0);
        `CHK("raw word", 32'h00800001, rd)
        apb(1, 17'h0CBFC, 32'h127FFFFF, 0);
        apb(0, 17'h0CBFC, 0, 0);
        `CHK("mirror top", 32'h007FFFFF, rd)
        apb(0, 17'h08BFC, 0, 0);
        `CHK("raw top", 32'h127FFFFF, rd)
        $display("test parameter ram done");
        THREAD_BUSY_IN <= 2'b01;
        apb(1, 17'h10, 32'h1, 0);
        repeat (4) @(posedge MCLK_IN);
        `CHK("drain", 2'b11, ENG_CLK_EN_OUT)
        THREAD_BUSY_IN <= 2'b00;
        repeat (2) @(posedge MCLK_IN);
        `CHK("engine off", 2'b10, ENG_CLK_EN_OUT)
        pad_drv <= 64'h1;
        repeat (8) @(posedge MCLK_IN);
        `CHK("frozen filter", 1'b0, CH_FILT_OUT[0])
        apb(0, 17'h200, 0, 0);
        apb(0, 17'h10, 0, 0);
        `CHK("off status", 1'b1, rd[31])
        apb(1, 17'h10, 32'h0, 0);
        repeat (6) @(posedge MCLK_IN);
        `CHK("engine on", 2'b11, ENG_CLK_EN_OUT)
        `CHK("filter w0", 1'b1, CH_FILT_OUT[0])
        pad_drv <= 64'h0;
        apb(1, 17'h10, 32'h30, 0);
        repeat (10) @(posedge MCLK_IN);
        pad_drv <= 64'h2;
        repeat (3) @(posedge MCLK_IN);
        pad_drv <= 64'h0;
        repeat (10) @(posedge MCLK_IN);
        `CHK("glitch", 1'b0, CH_FILT_OUT[1])
        pad_drv <= 64'h2;
        repeat (10) @(posedge MCLK_IN);
        `CHK("wide pulse", 1'b1, CH_FILT_OUT[1])
        pad_drv <= 64'h0;
        $display("test engine stop and filter done");
        apb(1, 17'h00480, 32'h2, 0);
        apb(1, 17'h00990, 32'h3, 0);
        CH_FORCE_EN_IN <= '1;
        CH_FORCE_VAL_IN <= 64'h0200000000000000;
        OUT_DIS_IN <= 8'h82;
        repeat (5) @(posedge MCLK_IN);
        `CHK("ch8", 1'b1, CH_OUT[8])
        `CHK("ch9", 1'b0, CH_OUT[9])
        `CHK("ch57", 1'b0, CH_OUT[57])
        OUT_DIS_IN <= 8'h02;
        repeat (5) @(posedge MCLK_IN);
        `CHK("ch57 free", 1'b1, CH_OUT[57])
        CH_FORCE_EN_IN <= '0;
        OUT_DIS_IN <= 8'h00;
        CH_ACT_VAL_IN <= 64'h8;
        CH_EVT_IN <= 64'h8;
        @(posedge MCLK_IN);
        CH_EVT_IN <= 64'h0;
        CH_OBE_IN <= 64'hF0;
        repeat (2) @(posedge MCLK_IN);
        `CHK("event level", 1'b1, CH_OUT[3])
        `CHK("buffer enables", 64'hF0, CH_OBE_OUT)
        $display("test outputs done");
        apb(1, 17'h18, 32'h100, 0);
        TB_CLK_IN <= 2'b10;
        repeat (8) @(posedge MCLK_IN);
        apb(0, 17'h44, 0, 0);
        c1 = rd;
        repeat (77) @(posedge MCLK_IN);
        apb(0, 17'h44, 0, 0);
        `CHK("pulse count", c1 + 32'd10, rd)
        TB_CLK_IN <= 2'b00;
        apb(1, 17'h10, 32'h200, 0);
        teeth = 0;
        repeat (3)
        begin
            TB_CLK_IN[0] <= 1'b1;
            repeat (4) @(posedge MCLK_IN);
            TB_CLK_IN[0] <= 1'b0;
            repeat (4) @(posedge MCLK_IN);
        end
        repeat (4) @(posedge MCLK_IN);
        `CHK("teeth", 3, teeth)
        $display("test time base done");
        SYS_STOP_IN <= 1'b1;
        repeat (6) @(posedge MCLK_IN);
        `CHK("stop ack", 1'b1, STOP_ACK_OUT)
        `CHK("stopped", 2'b00, ENG_CLK_EN_OUT)
        apb(0, 17'h14, 0, 0);
        `CHK("fill in stop", 32'hA5A50F0F, rd)
        SYS_STOP_IN <= 1'b0;
        repeat (6) @(posedge MCLK_IN);
        `CHK("resumed", 2'b11, ENG_CLK_EN_OUT)
        $display("test system stop done");
        complete_run();
    end
endmodule : tb_top

bind temp_top temp_bus_checker #(.NCH(NCH)) i_chk (.*);
